// >>> verilog/dmhbp_pkg.sv
/*
 package for the dual mode host bus port: bus style codes, state codes, word widths and timing counts.
 assumes a single 10 MHz core clock.
*/
package dmhbp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DEPTH = 256;
    // ready/acknowledge is held back this long after the strobe so read data is settled
    localparam int unsigned ACCESS_NS = 200;
    localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic STYLE_SEPARATE = 1'h1;
    localparam logic STYLE_DATASTROBE = 1'h0;
    localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;

    typedef enum logic [1:0] {
        DMHBP_IDLE = 2'h0,
        DMHBP_WAIT = 2'h1,
        DMHBP_DONE = 2'h2
    } dmhbp_state_e;
endpackage

// >>> verilog/dmhbp_mem.sv
/*
 small word memory behind the host port; read data come out of a register.
 assumes synchronous write enable and one read per clock.
*/
`timescale 1ns/1ps
module dmhbp_mem #(
    parameter int unsigned DATA_W = 16,
    parameter int unsigned DEPTH = 256,
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data_q
);
    logic [DATA_W-1:0] mem [DEPTH];

    initial begin
        if (DEPTH > (1 << ADDR_W)) begin
            $error("depth does not fit address width");
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data_q <= mem[addr];
    end
endmodule

// >>> verilog/dmhbp_port.sv
/*
 dual mode host bus port: pin level strobe decode, access sequencing, ready/acknowledge pin and interrupt pin.
 assumes host pins are synchronous to ref_clk and that the data bus is resolved outside from the enable.
*/
//Contract
//R01 - the static style select input picks separate strobes when high and data strobe with read/write when low.
//R02 - the board holds the reserved connection input high during operation.
//R03 - the host selects the port by pulling chip select low and strobes are ignored while it is high.
//R04 - the first strobe input is the low-active write strobe or, in data-strobe style, the read/write line.
//R05 - the second strobe input is the low-active read strobe or, in data-strobe style, the low-active data strobe.
//R06 - in data-strobe style the handshake pin pulls low to acknowledge and is otherwise released.
//R07 - in separate-strobe style the handshake pin is a driven ready while selected and floats when deselected.
//R08 - the interrupt pin is driven low while any condition is pending and is inactive otherwise.
//R09 - the host holds its strobe until ready or acknowledge, given only once read data is valid or write data taken.
`timescale 1ns/1ps
module dmhbp_port #(
    parameter int unsigned DATA_W = dmhbp_pkg::DATA_W,
    parameter int unsigned ADDR_W = dmhbp_pkg::ADDR_W,
    parameter int unsigned DEPTH = dmhbp_pkg::DEPTH,
    parameter int unsigned IRQ_W = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic style_sel,
    input wire logic reserved_high,
    input wire logic chip_sel_n,
    input wire logic write_or_rw,
    input wire logic read_or_ds_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out_q,
    output logic data_oe_q,
    output logic handshake_out_q,
    output logic handshake_oe_q,
    input wire logic [IRQ_W-1:0] irq_pending,
    output logic irq_n_q,
    output logic reserved_bad_q
);
    initial begin
        if (DATA_W < 1 || ADDR_W < 1 || IRQ_W < 1) begin
            $error("port widths must be at least one");
        end
        if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin
            $error("depth does not fit address width");
        end
        if (dmhbp_pkg::ACCESS_CYC < 1 || dmhbp_pkg::ACCESS_CYC > 255) begin
            $error("access count does not fit the wait counter");
        end
    end

    // arst_n leaves reset through two flops; the rest resets on that copy
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'h0;
            rst_n_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q <= rst_meta_q;
        end
    end

    // style strap is caught once after reset release
    logic style_q;
    logic style_taken_q;

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            style_q <= dmhbp_pkg::STYLE_SEPARATE;
            style_taken_q <= 1'h0;
        end else if (!style_taken_q) begin
            style_q <= style_sel; //R01
            style_taken_q <= 1'h1;
        end
    end

    logic sep;
    logic rd_req;
    logic wr_req;
    logic any_req;

    always_comb begin
        sep = (style_q == dmhbp_pkg::STYLE_SEPARATE);
        if (chip_sel_n || !style_taken_q) begin
            rd_req = 1'h0; //R03
            wr_req = 1'h0;
        end else if (sep) begin
            wr_req = !write_or_rw; //R04
            rd_req = !read_or_ds_n; //R05
        end else begin
            wr_req = !read_or_ds_n && !write_or_rw; //R04
            rd_req = !read_or_ds_n && write_or_rw; //R05
        end
        any_req = rd_req || wr_req;
    end

    dmhbp_pkg::dmhbp_state_e state_q;
    logic [7:0] wait_q;
    logic is_read_q;
    logic wait_over;

    assign wait_over = (wait_q <= 8'h01);

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= dmhbp_pkg::DMHBP_IDLE;
        end else begin
            case (state_q)
                dmhbp_pkg::DMHBP_IDLE: begin
                    if (any_req && !(rd_req && wr_req)) begin
                        state_q <= dmhbp_pkg::DMHBP_WAIT;
                    end
                end
                dmhbp_pkg::DMHBP_WAIT: begin
                    if (!any_req) begin
                        state_q <= dmhbp_pkg::DMHBP_IDLE;
                    end else if (wait_over) begin
                        state_q <= dmhbp_pkg::DMHBP_DONE; //R09
                    end
                end
                dmhbp_pkg::DMHBP_DONE: begin
                    if (!any_req) begin
                        state_q <= dmhbp_pkg::DMHBP_IDLE; //R09
                    end
                end
                default: begin
                    state_q <= dmhbp_pkg::DMHBP_IDLE;
                end
            endcase
        end
    end

    // access delay, reloaded while idle so every access waits the full count
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wait_q <= 8'h00;
        end else if (state_q == dmhbp_pkg::DMHBP_IDLE) begin
            wait_q <= 8'(dmhbp_pkg::ACCESS_CYC);
        end else if (state_q == dmhbp_pkg::DMHBP_WAIT && !wait_over) begin
            wait_q <= wait_q - 8'h01;
        end
    end

    // direction of the access in flight, fixed when it is taken
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            is_read_q <= 1'h0;
        end else if (state_q == dmhbp_pkg::DMHBP_IDLE && any_req) begin
            is_read_q <= rd_req;
        end
    end

    // write is captured on entry to wait, so acknowledge follows capture
    logic mem_wr;
    logic [DATA_W-1:0] mem_rd;

    assign mem_wr = (state_q == dmhbp_pkg::DMHBP_IDLE) && wr_req && !rd_req;

    dmhbp_mem #(
        .DATA_W(DATA_W),
        .DEPTH(DEPTH),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .clk(ref_clk),
        .wr_en(mem_wr),
        .addr(addr),
        .wr_data(data_in),
        .rd_data_q(mem_rd)
    );

    logic ack;

    assign ack = (state_q == dmhbp_pkg::DMHBP_DONE) && any_req;

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            data_out_q <= DATA_W'(dmhbp_pkg::RESET_WORD);
        end else if (state_q == dmhbp_pkg::DMHBP_WAIT && is_read_q) begin
            data_out_q <= mem_rd; //R09
        end
    end

    // data bus is only driven for a read that has been taken
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            data_oe_q <= 1'h0;
        end else begin
            data_oe_q <= is_read_q && rd_req && (state_q != dmhbp_pkg::DMHBP_IDLE); //R03
        end
    end

    // separate style drives ready while selected; data-strobe style only pulls low to acknowledge
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            handshake_out_q <= 1'h1;
            handshake_oe_q <= 1'h0;
        end else if (sep) begin
            handshake_out_q <= ack || !any_req; //R07
            handshake_oe_q <= !chip_sel_n; //R07
        end else begin
            handshake_out_q <= 1'h0; //R06
            handshake_oe_q <= ack; //R06
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_n_q <= 1'h1;
        end else begin
            irq_n_q <= !(|irq_pending); //R08
        end
    end

    // flags a board that leaves the reserved input low
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reserved_bad_q <= 1'h0;
        end else begin
            reserved_bad_q <= !reserved_high; //R02
        end
    end
endmodule

// >>> sim/dmhbp_port_monitor.sv
/*
 pin checker for the host bus port.
 assumes style_sel is static while arst_n is high.
*/
`timescale 1ns/1ps
module dmhbp_port_monitor #(
    parameter int unsigned IRQ_W = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic style_sel,
    input wire logic chip_sel_n,
    input wire logic write_or_rw,
    input wire logic read_or_ds_n,
    input wire logic data_oe_q,
    input wire logic handshake_out_q,
    input wire logic handshake_oe_q,
    input wire logic [IRQ_W-1:0] irq_pending,
    input wire logic irq_n_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence sep_go;
        style_sel && !chip_sel_n && (read_or_ds_n != write_or_rw) && $fell(read_or_ds_n && write_or_rw);
    endsequence
    sequence ds_go; !style_sel && !chip_sel_n && $fell(read_or_ds_n); endsequence
    desel_float_a: assert property (chip_sel_n ##1 chip_sel_n |-> !handshake_oe_q)
        else $error("handshake driven while deselected");
    sel_drive_a: assert property (style_sel && !chip_sel_n ##1 !chip_sel_n |-> handshake_oe_q)
        else $error("ready not driven while selected");
    desel_ignore_a: assert property (chip_sel_n ##1 chip_sel_n |-> !data_oe_q)
        else $error("data driven while deselected");
    ds_pull_a: assert property (!style_sel && handshake_oe_q |-> !handshake_out_q)
        else $error("acknowledge driven high");
    sep_ready_a: assert property (sep_go |=> !handshake_out_q [*2] ##[1:2] handshake_out_q)
        else $error("ready timing wrong");
    ds_ack_a: assert property (ds_go |=> !handshake_oe_q [*2] ##[1:2] (handshake_oe_q && !handshake_out_q))
        else $error("acknowledge timing wrong");
    read_valid_a: assert property (!style_sel && handshake_oe_q && write_or_rw && !read_or_ds_n |-> data_oe_q)
        else $error("acknowledge before read data");
    irq_low_a: assert property ((|irq_pending) |=> !irq_n_q)
        else $error("interrupt not asserted");
    irq_idle_a: assert property (!(|irq_pending) |=> irq_n_q)
        else $error("interrupt asserted with nothing pending");
    cover property (sep_go);
    cover property (ds_go);
    cover property (!irq_n_q);
endmodule

bind dmhbp_port dmhbp_port_monitor #(.IRQ_W(IRQ_W)) i_mon (.ref_clk, .arst_n, .style_sel, .chip_sel_n,
    .write_or_rw, .read_or_ds_n, .data_oe_q, .handshake_out_q, .handshake_oe_q, .irq_pending, .irq_n_q);

// >>> sim/dmhbp_host_model.sv
/*
 host side pin model: resolves the handshake pin and ties the reserved input.
 assumes strobes come from the bench tasks.
*/
`timescale 1ns/1ps
module dmhbp_host_model (
    input wire logic style_sel,
    input wire logic hs_out,
    input wire logic hs_oe,
    output logic hs_pin,
    output logic reserved_high
);
    assign reserved_high = 1'h1;
    // released: pull-up in data strobe style, inverse of hs_out in separate style
    assign hs_pin = hs_oe ? hs_out : (style_sel ? !hs_out : 1'h1);
endmodule

// >>> sim/dmhbp_port_tb_top.sv
/*
 testbench for the host bus port.
 assumes a 10 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module dmhbp_port_tb_top;
    logic ref_clk, arst_n, style_sel, chip_sel_n, write_or_rw, read_or_ds_n, reserved_high, hs_pin;
    logic data_oe_q, handshake_out_q, handshake_oe_q, irq_n_q, reserved_bad_q;
    logic [7:0] addr;
    logic [15:0] data_in, data_out_q, q;
    logic [3:0] irq_pending;
    int n_fail, tests_run, cyc;
    dmhbp_port i_dut (.ref_clk, .arst_n, .style_sel, .reserved_high, .chip_sel_n, .write_or_rw,
        .read_or_ds_n, .addr, .data_in, .data_out_q, .data_oe_q, .handshake_out_q, .handshake_oe_q,
        .irq_pending, .irq_n_q, .reserved_bad_q);
    dmhbp_host_model i_host (.style_sel, .hs_out(handshake_out_q), .hs_oe(handshake_oe_q), .hs_pin,
        .reserved_high);
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic boot(input logic s);
        arst_n = 1'h0;
        style_sel = s;
        repeat (20) @(negedge ref_clk);
        arst_n = 1'h1;
        repeat (6) @(negedge ref_clk);
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
        int n;
        n = 0;
        addr = a;
        data_in = d;
        chip_sel_n = 1'h0;
        write_or_rw = !wr;
        read_or_ds_n = style_sel ? wr : 1'h0;
        @(negedge ref_clk);
        while (hs_pin !== style_sel && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(hs_pin, style_sel)
        r = data_out_q;
        chip_sel_n = 1'h1;
        write_or_rw = 1'h1;
        read_or_ds_n = 1'h1;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic t_rw(input logic [7:0] a, input logic [15:0] d);
        acc(1'h1, a, d, q);
        acc(1'h0, a, 16'h0000, q);
        `CHK(q, d)
    endtask
    task automatic t_desel();
        chip_sel_n = 1'h1;
        data_in = 16'hFFFF;
        write_or_rw = 1'h0;
        repeat (6) @(negedge ref_clk);
        `CHK(handshake_oe_q, 1'h0)
        chip_sel_n = 1'h0;
        read_or_ds_n = 1'h0;
        repeat (6) @(negedge ref_clk);
        `CHK(data_oe_q, 1'h0)
        {chip_sel_n, write_or_rw, read_or_ds_n} = 3'h7;
        @(negedge ref_clk);
        acc(1'h0, 8'h12, 16'h0000, q);
        `CHK(q, 16'hA5C3)
    endtask
    task automatic t_irq();
        irq_pending = 4'h8;
        repeat (2) @(negedge ref_clk);
        `CHK(irq_n_q, 1'h0)
        irq_pending = 4'h0;
        repeat (2) @(negedge ref_clk);
        `CHK(irq_n_q, 1'h1)
        `CHK(reserved_bad_q, 1'h0)
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = !ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {chip_sel_n, write_or_rw, read_or_ds_n} = 3'h7;
        addr = 8'h00;
        data_in = 16'h0000;
        irq_pending = 4'h0;
        boot(1'h1);
        t_rw(8'h12, 16'hA5C3);
        t_desel();
        t_irq();
        boot(1'h0);
        t_rw(8'h3F, 16'h5A0F);
        `CHK(hs_pin, 1'h1)
        t_irq();
        wrap_up();
    end
endmodule
